// File: logic/config_bank_zero.v
// Bank-zero configuration registers behind the serial configuration port
`include "config_bank_zero_regs.vh"

module config_bank_zero (
    // Clock, reset, enable
    input  wire        i_clk,
    input  wire        i_reset_n,
    input  wire        i_ce,
    // Serial configuration pins
    input  wire        i_cs_n,
    input  wire        i_sclk,
    input  wire        i_sdi,
    output wire        o_sdo,
    // Other banks, same clock
    output reg         o_ext_wr,
    output reg  [7:0]  o_ext_addr,
    output reg  [15:0] o_ext_wdata,
    input  wire [15:0] i_ext_rdata,
    // Configuration outputs
    output wire [4:0]  o_chain_length,
    output wire [7:0]  o_bank_select,
    output wire [3:0]  o_init_key,
    output wire        o_legacy_mode,
    output wire        o_read_enable,
    output reg         o_adc_reset
);

    wire        cs_n_s;
    wire        sclk_s;
    wire        sdi_s;
    reg         sclk_d_reg;
    reg         cs_n_d_reg;
    reg  [23:0] rx_reg;
    reg  [23:0] tx_reg;
    reg         sdo_reg;
    reg  [9:0]  bit_count_reg;
    reg  [15:0] control_reg;
    reg  [4:0]  chain_len_reg;
    reg  [7:0]  bank_sel_reg;
    reg  [3:0]  init_key_reg;

    wire        sclk_rise;
    wire        sclk_fall;
    wire        cs_rise;
    wire        cs_fall;
    wire [9:0]  frame_bits;
    wire        frame_ok;
    wire [7:0]  cmd_byte;
    wire [7:0]  addr_byte;
    wire [15:0] data_word;
    wire        legacy_reads;
    wire        daisy_read;
    wire        is_read;
    wire        bank_zero;
    wire        always_mapped;
    wire [7:0]  read_addr;
    wire        read_mapped;
    wire [15:0] mirror_value;
    reg  [15:0] read_value;

    // Pin synchronisers
    // CS idles high, so its flops reset high and no false edge follows reset
    pin_sync #(.RESET_LEVEL(1'b1)) u_sync_cs (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_ce      (i_ce),
        .i_pin     (i_cs_n),
        .o_level   (cs_n_s)
    );

    pin_sync u_sync_sclk (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_ce      (i_ce),
        .i_pin     (i_sclk),
        .o_level   (sclk_s)
    );

    pin_sync u_sync_sdi (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_ce      (i_ce),
        .i_pin     (i_sdi),
        .o_level   (sdi_s)
    );

    // Edge detection on synchronised pins
    assign sclk_rise = sclk_s & ~sclk_d_reg & ~cs_n_s;
    assign sclk_fall = ~sclk_s & sclk_d_reg & ~cs_n_s;
    assign cs_rise   = cs_n_s & ~cs_n_d_reg;
    assign cs_fall   = ~cs_n_s & cs_n_d_reg;

    // Expected frame length follows the chain size outside legacy mode, one word in legacy mode
    assign frame_bits = o_legacy_mode ? `FRAME_BITS
                      : `FRAME_BITS * ({5'h00, chain_len_reg} + `BIT_COUNT_ONE);
    assign frame_ok   = (bit_count_reg == frame_bits);

    // Frame fields: command, address, data
    assign cmd_byte  = rx_reg[`FRAME_MSB:16];
    assign addr_byte = rx_reg[`FRAME_MSB:16];
    assign data_word = rx_reg[15:0];

    // Read selection per mode
    assign legacy_reads = o_legacy_mode & o_read_enable;
    assign daisy_read   = ~o_legacy_mode & (cmd_byte == `DAISY_READ_CMD);
    assign is_read      = legacy_reads | daisy_read;

    // Bank routing; control word and selector stay reachable from any bank
    assign bank_zero     = (bank_sel_reg == `BANK_CODE_ZERO);
    assign always_mapped = (addr_byte == `ADDR_CONTROL_WORD) | (addr_byte == `ADDR_BANK_SELECT);

    // Mirror shows the control word with read enable reported set
    assign mirror_value = control_reg | (16'h0001 << `CTRL_READ_EN_BIT);

    // Address a read refers to; control word and selector stay local in every bank
    assign read_addr   = daisy_read ? data_word[7:0] : addr_byte;
    assign read_mapped = (read_addr == `ADDR_CONTROL_WORD) | (read_addr == `ADDR_BANK_SELECT);

    // Read data selection
    always @* begin
        read_value = 16'h0000;
        if (!bank_zero && !read_mapped) begin
            read_value = i_ext_rdata;
        end else begin
            case (read_addr)
                `ADDR_CHAIN_LENGTH:   read_value[`CHAIN_LEN_MSB:`CHAIN_LEN_LSB] = chain_len_reg;
                `ADDR_BANK_SELECT:    read_value[`BANK_SEL_MSB:0] = bank_sel_reg;
                `ADDR_INIT_KEY_ONE:   read_value[`INIT_KEY_MSB:0] = init_key_reg;
                `ADDR_CONTROL_MIRROR: read_value = mirror_value;
                default:              read_value = 16'h0000;
            endcase
        end
    end

    // Serial shifting, frame commit and register updates
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sclk_d_reg     <= 1'b0;
            cs_n_d_reg     <= 1'b1;
            rx_reg         <= 24'h000000;
            tx_reg         <= 24'h000000;
            sdo_reg        <= 1'b0;
            bit_count_reg  <= `BIT_COUNT_ZERO;
            control_reg    <= `RST_CONTROL_WORD;
            chain_len_reg  <= `RST_CHAIN_LENGTH;
            bank_sel_reg   <= `RST_BANK_SELECT;
            init_key_reg   <= `RST_INIT_KEY_ONE;
            o_ext_wr       <= 1'b0;
            o_ext_addr     <= 8'h00;
            o_ext_wdata    <= 16'h0000;
            o_adc_reset    <= 1'b0;
        end else if (i_ce) begin
            sclk_d_reg  <= sclk_s;
            cs_n_d_reg  <= cs_n_s;
            o_ext_wr    <= 1'b0;
            o_adc_reset <= 1'b0;
            // Sample on rising SCLK; data passes through with a 24-clock delay
            if (sclk_rise) begin
                rx_reg <= {rx_reg[22:0], sdi_s};
                tx_reg <= {tx_reg[22:0], sdi_s};
                if (bit_count_reg != `BIT_COUNT_MAX) begin
                    bit_count_reg <= bit_count_reg + `BIT_COUNT_ONE;
                end
            end
            // Drive SDO on falling SCLK or at frame start
            if (sclk_fall || cs_fall) begin
                sdo_reg <= tx_reg[`FRAME_MSB];
            end
            if (cs_fall) begin
                bit_count_reg <= `BIT_COUNT_ZERO;
            end
            // Frame commit at chip-select release
            if (cs_rise && frame_ok) begin
                if (is_read) begin
                    tx_reg <= {read_addr, read_value};
                end else begin
                    if (addr_byte == `ADDR_CONTROL_WORD) begin
                        control_reg <= data_word;
                        control_reg[`CTRL_SOFT_RESET_BIT] <= 1'b0;
                        if (data_word[`CTRL_SOFT_RESET_BIT]) begin
                            control_reg   <= `RST_CONTROL_WORD;
                            chain_len_reg <= `RST_CHAIN_LENGTH;
                            bank_sel_reg  <= `RST_BANK_SELECT;
                            init_key_reg  <= `RST_INIT_KEY_ONE;
                            o_adc_reset   <= 1'b1;
                        end
                    end else if (addr_byte == `ADDR_BANK_SELECT) begin
                        bank_sel_reg <= data_word[`BANK_SEL_MSB:0];
                    end else if (!bank_zero && !always_mapped) begin
                        o_ext_wr    <= 1'b1;
                        o_ext_addr  <= addr_byte;
                        o_ext_wdata <= data_word;
                    end else if (addr_byte == `ADDR_CHAIN_LENGTH) begin
                        chain_len_reg <= data_word[`CHAIN_LEN_MSB:`CHAIN_LEN_LSB];
                    end else if (addr_byte == `ADDR_INIT_KEY_ONE) begin
                        init_key_reg <= data_word[`INIT_KEY_MSB:0];
                    end
                end
            end
        end
    end

    // Configuration outputs
    assign o_sdo          = sdo_reg;
    assign o_chain_length = chain_len_reg;
    assign o_bank_select  = bank_sel_reg;
    assign o_init_key     = init_key_reg;
    assign o_legacy_mode  = control_reg[`CTRL_LEGACY_MODE_BIT];
    assign o_read_enable  = control_reg[`CTRL_READ_EN_BIT];

endmodule

// File: common/config_bank_zero_regs.vh
// Offsets, field positions, reset values and frame constants of the bank-zero registers
`ifndef CONFIG_BANK_ZERO_REGS_VH
`define CONFIG_BANK_ZERO_REGS_VH

// Register addresses
`define ADDR_CONTROL_WORD     8'h00
`define ADDR_CHAIN_LENGTH     8'h01
`define ADDR_BANK_SELECT      8'h03
`define ADDR_INIT_KEY_ONE     8'h04
`define ADDR_CONTROL_MIRROR   8'h06

// Control word fields
`define CTRL_SOFT_RESET_BIT   0
`define CTRL_READ_EN_BIT      1
`define CTRL_LEGACY_MODE_BIT  2

// Chain length field position
`define CHAIN_LEN_MSB         6
`define CHAIN_LEN_LSB         2

// Bank selector field and codes
`define BANK_SEL_MSB          7
`define BANK_CODE_ZERO        8'h00
`define BANK_CODE_ONE         8'h02
`define BANK_CODE_TWO         8'h10

// Init key field
`define INIT_KEY_MSB          3

// Reset values
`define RST_CONTROL_WORD      16'h0000
`define RST_CHAIN_LENGTH      5'h00
`define RST_BANK_SELECT       8'h02
`define RST_INIT_KEY_ONE      4'h0

// Frame format
`define FRAME_BITS            10'h018
`define FRAME_MSB             23
`define DAISY_READ_CMD        8'hFE
`define BIT_COUNT_ZERO        10'h000
`define BIT_COUNT_ONE         10'h001
`define BIT_COUNT_MAX         10'h3FF

`endif

// File: logic/pin_sync.v
// Two-flop synchroniser for one pin input
module pin_sync #(
    // Level both flops take in reset, the idle level of the pin
    parameter RESET_LEVEL = 1'b0
) (
    // Clock and reset
    input  wire i_clk,
    input  wire i_reset_n,
    input  wire i_ce,
    // Pin in, synchronised level out
    input  wire i_pin,
    output wire o_level
);

    reg meta_reg;
    reg level_reg;

    // First flop feeds only the second
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_reg  <= RESET_LEVEL;
            level_reg <= RESET_LEVEL;
        end else if (i_ce) begin
            meta_reg  <= i_pin;
            level_reg <= meta_reg;
        end
    end

    assign o_level = level_reg;

endmodule

// File: tb/config_bank_zero_chk.sv
// Checker of the bank-zero register outputs
module config_bank_zero_chk (
    input wire       i_clk,
    input wire       i_reset_n,
    input wire       i_cs_n,
    input wire       o_ext_wr,
    input wire [7:0] o_bank_select,
    input wire [4:0] o_chain_length,
    input wire [3:0] o_init_key,
    input wire       o_legacy_mode,
    input wire       o_read_enable,
    input wire       o_adc_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // Defaults right after reset
    AST_BANK_RST: assert property ($rose(i_reset_n) |-> o_bank_select == 8'h02)
        else $error("bank selector not at default");
    AST_CFG_RST: assert property ($rose(i_reset_n) |-> o_chain_length == 5'h00 && !o_legacy_mode)
        else $error("configuration not at default");
    // Other-bank writes
    AST_EXT_PULSE: assert property (o_ext_wr |=> !o_ext_wr)
        else $error("other-bank write longer than one cycle");
    AST_EXT_BANK: assert property (o_ext_wr |-> o_bank_select != 8'h00)
        else $error("other-bank write while bank zero selected");
    AST_EXT_IN_FRAME: assert property (!i_cs_n [*5] |=> !o_ext_wr)
        else $error("other-bank write inside a frame");
    // Nothing commits while a frame runs
    AST_BANK_HOLD: assert property (!i_cs_n [*5] |=> $stable(o_bank_select))
        else $error("bank selector changed inside a frame");
    AST_CHAIN_HOLD: assert property (!i_cs_n [*5] |=> $stable(o_chain_length))
        else $error("chain length changed inside a frame");
    AST_KEY_HOLD: assert property (!i_cs_n [*5] |=> $stable(o_init_key))
        else $error("init key changed inside a frame");
    AST_MODE_HOLD: assert property (!i_cs_n [*5] |=> $stable({o_legacy_mode, o_read_enable}))
        else $error("mode bits changed inside a frame");
    // Control-word reset restores defaults in the same cycle as its pulse
    AST_ADC_RST_PULSE: assert property (o_adc_reset |=> !o_adc_reset)
        else $error("control reset pulse longer than one cycle");
    AST_ADC_RST_DEF: assert property (o_adc_reset |-> o_bank_select == 8'h02 && o_chain_length == 5'h00)
        else $error("defaults not restored with control reset");
    COV_EXT: cover property (o_ext_wr);
    COV_ADC_RST: cover property (o_adc_reset);
    COV_LEGACY: cover property (o_legacy_mode && o_read_enable);
    COV_CHAIN: cover property (o_chain_length == 5'h1F);
endmodule

bind config_bank_zero config_bank_zero_chk chk_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_cs_n(i_cs_n),
    .o_ext_wr(o_ext_wr), .o_bank_select(o_bank_select), .o_chain_length(o_chain_length),
    .o_init_key(o_init_key), .o_legacy_mode(o_legacy_mode), .o_read_enable(o_read_enable),
    .o_adc_reset(o_adc_reset));

// File: tb/spi_ctrl_model.sv
// Serial configuration controller model
module spi_ctrl_model (
    input  wire  i_clk,
    input  wire  i_sdo,
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_sdi
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_sdi  = 1'b0;
    end
    // One frame of repeated words, MSB first, four clocks per SCLK phase
    task automatic frame(input logic [23:0] word, input int words, output logic [23:0] rx);
        int i;
        rx = 24'h000000;
        @(posedge i_clk) o_cs_n <= 1'b0;
        o_sdi <= word[23];
        for (i = 0; i < 24 * words; i++) begin
            repeat (3) @(posedge i_clk);
            @(negedge i_clk) rx = {rx[22:0], i_sdo};
            @(posedge i_clk) o_sclk <= 1'b1;
            repeat (4) @(posedge i_clk);
            o_sclk <= 1'b0;
            o_sdi  <= word[23 - ((i + 1) % 24)];
        end
        repeat (4) @(posedge i_clk);
        o_cs_n <= 1'b1;
        o_sdi  <= ~o_sdi; // Released line shows no stale level
        repeat (8) @(posedge i_clk);
    endtask
endmodule

// File: tb/config_bank_zero_tb.sv
// Testbench of the bank-zero registers
module config_bank_zero_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk = 1'b0;
    logic        i_reset_n = 1'b0;
    logic        i_ce = 1'b1;
    logic [15:0] i_ext_rdata = 16'h0000;
    wire         cs_n, sclk, sdi, o_sdo, o_ext_wr, o_legacy_mode, o_read_enable, o_adc_reset;
    wire  [7:0]  o_ext_addr, o_bank_select;
    wire  [15:0] o_ext_wdata;
    wire  [4:0]  o_chain_length;
    wire  [3:0]  o_init_key;
    int          fails = 0, cmp_count = 0, cycles = 0, ext_count = 0, adc_count = 0;
    logic [23:0] rx;
    always #12.5 i_clk = ~i_clk;
    config_bank_zero dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(i_ce), .i_cs_n(cs_n),
        .i_sclk(sclk), .i_sdi(sdi), .o_sdo(o_sdo), .o_ext_wr(o_ext_wr), .o_ext_addr(o_ext_addr),
        .o_ext_wdata(o_ext_wdata), .i_ext_rdata(i_ext_rdata), .o_chain_length(o_chain_length),
        .o_bank_select(o_bank_select), .o_init_key(o_init_key), .o_legacy_mode(o_legacy_mode),
        .o_read_enable(o_read_enable), .o_adc_reset(o_adc_reset));
    spi_ctrl_model ctrl_u (.i_clk(i_clk), .i_sdo(o_sdo), .o_cs_n(cs_n), .o_sclk(sclk), .o_sdi(sdi));
    // Cycle limit, other-bank write count and control-reset pulse count
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (o_ext_wr === 1'b1) ext_count <= ext_count + 1;
        if (o_adc_reset === 1'b1) adc_count <= adc_count + 1;
        if (cycles == 30000) begin
            fails++;
            end_sim();
        end
    end
    task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        ctrl_u.frame({a, d}, 1, rx);
    endtask
    task automatic rd(input logic [7:0] a);
        ctrl_u.frame({8'hFE, 8'h00, a}, 1, rx);
        ctrl_u.frame(24'hFFFFFF, 1, rx);
    endtask
    task automatic reset_dut();
        @(posedge i_clk) i_reset_n <= 1'b0;
        repeat (3) @(posedge i_clk);
        i_reset_n <= 1'b1;
        repeat (3) @(posedge i_clk);
    endtask
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Main sequence; reserved bits sent as zero except in the all-ones filler frame of each read
    initial begin
        reset_dut();
        check("bank", 24'h000002, {16'h0000, o_bank_select});
        wr(8'h04, 16'h000B);
        check("ext", {8'h01, 8'h04, 8'h00}, {ext_count[7:0], o_ext_addr, 8'h00});
        check("ext_data", 24'h00000B, {8'h00, o_ext_wdata});
        check("key_untouched", 24'h000000, {20'h00000, o_init_key});
        wr(8'h03, 16'h0010);
        i_ext_rdata <= 16'hA5C3;
        rd(8'h20);
        check("ext_read", 24'h20A5C3, rx);
        rd(8'h03);
        check("bank_read", 24'h030010, rx);
        wr(8'h03, 16'h0000);
        check("bank0", 24'h000000, {16'h0000, o_bank_select});
        wr(8'h04, 16'h000B);
        check("key", 24'h00000B, {20'h00000, o_init_key});
        // A frozen block ignores a whole frame
        i_ce <= 1'b0;
        wr(8'h04, 16'h0000);
        i_ce <= 1'b1;
        check("ce_freeze", 24'h00000B, {20'h00000, o_init_key});
        rd(8'h06);
        check("mirror", 24'h060002, rx);
        rd(8'h00);
        check("ctrl_hidden", 24'h000000, rx);
        wr(8'h00, 16'h0006);
        check("modes", 24'h000003, {22'h000000, o_legacy_mode, o_read_enable});
        ctrl_u.frame(24'h060000, 1, rx);
        ctrl_u.frame(24'h060000, 1, rx);
        check("mirror_legacy", 24'h060006, rx);
        reset_dut();
        check("bank_again", 24'h000002, {16'h0000, o_bank_select});
        wr(8'h03, 16'h0000);
        wr(8'h01, 16'h007C);
        check("chain", 24'h00001F, {19'h00000, o_chain_length});
        wr(8'h04, 16'h000B);
        check("short_frame", 24'h000000, {20'h00000, o_init_key});
        ctrl_u.frame(24'h04000B, 32, rx);
        check("long_frame", 24'h00000B, {20'h00000, o_init_key});
        check("pass_through", 24'h04000B, rx);
        // Control-word reset bit restores defaults and pulses the converter reset
        ctrl_u.frame(24'h000001, 32, rx);
        check("adc_reset", 24'h000001, adc_count[23:0]);
        check("soft_defaults", 24'h020000, {o_bank_select, 11'h000, o_chain_length});
        end_sim();
    end
endmodule
